// ---- core/lmsg_defines.svh ----
// Purpose: constants of the LED matrix scan and gain block
// Assumes: 50 MHz aclk, AXI4-Lite register access
// Notes:   times in ns or ps, cycle counts derived from them
// What this block does
// - Eighteen sinks against two scan lines, lines scanned 0 then 1, repeating.
// - Line count field picks one or two active lines; scan cycles only those.
// - Line slot equals sink active time plus blank plus twice the stagger.
// - Sink active time is 8 us at 125 kHz, 16 us at 62.5 kHz.
// - Blank between line switches is 1 us or 0.5 us by blank select.
// - Stagger time is zero when disabled, 125 ns when enabled.
// - Sub-period is line slot times number of active lines.
// - Turn-on delay bit postpones sink turn-on after the line starts.
// - A line that is off is discharged and clamped at the selected level.
// - A sink that is off is pre-charged at the selected strength.
// - Three compensation groups; sink index modulo three picks the group.
// - Peak code 0..7 maps to 3,5,10,15,20,30,40,50 mA.
// - Peak code resets to 011, which is 15 mA.
// - In instant refresh mode a new peak code applies at once.
// - Frame modes: peak code changed with run off, applied when run returns.
// - Precharge and discharge fields latch exactly like the peak code.
// - Three 7-bit color gains scale by code over 127; default 64.
// - Color group fixed by sink index modulo three.
// - Each dot has an 8-bit dot gain, 256 steps, default 128.
// - Sink current is peak times color over 127 times dot over 255.
// - Average dot current is sink current divided by active line count.
// - Each dot has its own 8- or 16-bit duty; 16-bit uses spread spectrum.
// - Instant mode duty applies at once; frame modes wait for sync pulse.
`ifndef LMSG_DEFINES_SVH
`define LMSG_DEFINES_SVH

`define LMSG_CLK_PS        20000
`define LMSG_CYC_UP(ps)    (((ps) + `LMSG_CLK_PS - 1) / `LMSG_CLK_PS)
`define LMSG_PWM_FAST_PS   8000000
`define LMSG_PWM_SLOW_PS   16000000
`define LMSG_BLK_LONG_PS   1000000
`define LMSG_BLK_SHORT_PS  500000
`define LMSG_STG_PS        125000
`define LMSG_DLY_FAST_PS   31250
`define LMSG_DLY_SLOW_PS   62500
`define LMSG_PWM_FAST_CYC  `LMSG_CYC_UP(`LMSG_PWM_FAST_PS)
`define LMSG_PWM_SLOW_CYC  `LMSG_CYC_UP(`LMSG_PWM_SLOW_PS)
`define LMSG_BLK_LONG_CYC  `LMSG_CYC_UP(`LMSG_BLK_LONG_PS)
`define LMSG_BLK_SHORT_CYC `LMSG_CYC_UP(`LMSG_BLK_SHORT_PS)
`define LMSG_STG_CYC       `LMSG_CYC_UP(`LMSG_STG_PS)
`define LMSG_DLY_FAST_CYC  `LMSG_CYC_UP(`LMSG_DLY_FAST_PS)
`define LMSG_DLY_SLOW_CYC  `LMSG_CYC_UP(`LMSG_DLY_SLOW_PS)
`define LMSG_STEP_FAST     (65536 / `LMSG_PWM_FAST_CYC)
`define LMSG_STEP_SLOW     (65536 / `LMSG_PWM_SLOW_CYC)

`define LMSG_PEAK0_UA      16'd3000
`define LMSG_PEAK1_UA      16'd5000
`define LMSG_PEAK2_UA      16'd10000
`define LMSG_PEAK3_UA      16'd15000
`define LMSG_PEAK4_UA      16'd20000
`define LMSG_PEAK5_UA      16'd30000
`define LMSG_PEAK6_UA      16'd40000
`define LMSG_PEAK7_UA      16'd50000
`define LMSG_GAIN_DIV      31'd32385

`define LMSG_A_CTRL        12'h000
`define LMSG_A_TIMING      12'h004
`define LMSG_A_COMP        12'h008
`define LMSG_A_DEGHOST     12'h00c
`define LMSG_A_PEAK        12'h010
`define LMSG_A_COLOR       12'h014
`define LMSG_A_GSEL        12'h018
`define LMSG_A_GOUT        12'h01c
`define LMSG_A_STATUS      12'h020
`define LMSG_A_DOTG_PAGE   4'h1
`define LMSG_A_DUTY_PAGE   4'h2

`define LMSG_PEAK_RST      3'h3
`define LMSG_COLOR_RST     7'h40
`define LMSG_DOTG_RST      8'h80
`define LMSG_RESP_OKAY     2'h0
`define LMSG_RESP_SLVERR   2'h2

`endif

// ---- core/lmsg_pkg.sv ----
// Purpose: shared types of the LED matrix scan and gain block
// Assumes: nothing beyond the defines header
// Notes:   scan states are one-hot
package lmsg_pkg;

  typedef enum logic [1:0] {
    LMSG_INSTANT = 2'h0,
    LMSG_FRAME8  = 2'h1,
    LMSG_FRAME16 = 2'h2
  } lmsg_mode_e;

  typedef enum logic [2:0] {
    LMSG_IDLE   = 3'h1,
    LMSG_BLANK  = 3'h2,
    LMSG_ACTIVE = 3'h4
  } lmsg_scan_e;

endpackage

// ---- core/lmsg_gain_calc.sv ----
// Purpose: sink and average current of one dot from its gain codes
// Assumes: codes already latched by the caller
// Notes:   result in microamps, truncated
`timescale 1ns/1ps
`include "lmsg_defines.svh"
module lmsg_gain_calc (
  // Gain codes
  input  wire logic [2:0]  peak_code,
  input  wire logic [6:0]  color_code,
  input  wire logic [7:0]  dot_code,
  input  wire logic        two_lines,
  // Currents
  output logic      [15:0] sink_ua,
  output logic      [15:0] avg_ua
);
  logic [15:0] peak_ua;
  logic [30:0] prod;

  always_comb begin
    case (peak_code)
      3'h0:    peak_ua = `LMSG_PEAK0_UA;
      3'h1:    peak_ua = `LMSG_PEAK1_UA;
      3'h2:    peak_ua = `LMSG_PEAK2_UA;
      3'h3:    peak_ua = `LMSG_PEAK3_UA;
      3'h4:    peak_ua = `LMSG_PEAK4_UA;
      3'h5:    peak_ua = `LMSG_PEAK5_UA;
      3'h6:    peak_ua = `LMSG_PEAK6_UA;
      default: peak_ua = `LMSG_PEAK7_UA;
    endcase
  end

  assign prod    = 31'(peak_ua) * 31'(color_code) * 31'(dot_code);
  assign sink_ua = 16'(prod / `LMSG_GAIN_DIV);
  assign avg_ua  = two_lines ? {1'b0, sink_ua[15:1]} : sink_ua;
endmodule

// ---- core/lmsg_top.sv ----
// Purpose: scan sequencer, slot timing and current gain of the LED matrix
// Assumes: AXI4-Lite master keeps one write and one read in flight
// Notes:   sink_on and line_on lag the scan state by one cycle
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "lmsg_defines.svh"
module lmsg_top #(
  parameter int LINES = 2,
  parameter int SINKS = 18
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // Write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // Read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Frame sync pin
  input  wire logic        vsync,
  // Scan lines
  output logic [LINES-1:0] line_on,
  output logic [LINES-1:0] line_discharge,
  output logic [1:0]       line_discharge_level,
  // Current sinks
  output logic [SINKS-1:0] sink_on,
  output logic [SINKS-1:0] sink_precharge,
  output logic [1:0]       sink_precharge_level,
  output logic [1:0]       low_level_comp_first,
  output logic [1:0]       low_level_comp_second,
  output logic [1:0]       low_level_comp_third
);
  localparam int DOTS = LINES * SINKS;
  localparam int LW   = $clog2(LINES);

  typedef struct packed {
    logic                    awready;
    logic                    wready;
    logic                    arready;
    logic                    aw_hold;
    logic                    w_hold;
    logic [11:0]             awaddr;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic                    run;
    logic                    run_prev;
    lmsg_pkg::lmsg_mode_e    mode;
    logic                    two_lines;
    logic                    rate_slow;
    logic                    blank_short;
    logic                    stagger;
    logic                    delay_en;
    logic [5:0]              comp;
    logic [1:0]              dis_sel;
    logic [1:0]              pre_sel;
    logic [2:0]              peak;
    logic [1:0]              eff_dis;
    logic [1:0]              eff_pre;
    logic [2:0]              eff_peak;
    logic [2:0][6:0]         color;
    logic [5:0]              sel_dot;
    logic [15:0]             cur_ua;
    logic [15:0]             avg_ua;
    logic [DOTS-1:0][7:0]    dot_gain;
    logic [DOTS-1:0][15:0]   duty_sh;
    logic [DOTS-1:0][15:0]   duty_act;
    logic                    vs1;
    logic                    vs2;
    logic                    vs3;
    lmsg_pkg::lmsg_scan_e    state;
    logic [LW-1:0]           line;
    logic [10:0]             tcnt;
    logic [7:0]              subcnt;
    logic [LINES-1:0]        line_on;
    logic [LINES-1:0]        line_dis;
    logic [SINKS-1:0]        sink_on;
    logic [SINKS-1:0]        sink_pre;
  } lmsg_state_s;

  lmsg_state_s q;
  lmsg_state_s d;
  logic [15:0] g_cur;
  logic [15:0] g_avg;

  // index modulo three picks the group
  function automatic logic [1:0] grp(input int idx);
    grp = 2'(idx % 3);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int b = 0; b < 8; b++) begin
      rev8[b] = v[7-b];
    end
  endfunction

  // Register map lookup, shared by read path and write merge
  function automatic logic reg_read(input logic [11:0] a, output logic [31:0] v);
    reg_read = 1'b1;
    v = 32'h0;
    if (a == `LMSG_A_CTRL) begin
      v = {28'h0, q.two_lines, q.mode, q.run};
    end else if (a == `LMSG_A_TIMING) begin
      v = {28'h0, q.delay_en, q.stagger, q.blank_short, q.rate_slow};
    end else if (a == `LMSG_A_COMP) begin
      v = {26'h0, q.comp};
    end else if (a == `LMSG_A_DEGHOST) begin
      v = {28'h0, q.pre_sel, q.dis_sel};
    end else if (a == `LMSG_A_PEAK) begin
      v = {29'h0, q.peak};
    end else if (a == `LMSG_A_COLOR) begin
      v = {9'h0, q.color[2], 1'b0, q.color[1], 1'b0, q.color[0]};
    end else if (a == `LMSG_A_GSEL) begin
      v = {26'h0, q.sel_dot};
    end else if (a == `LMSG_A_GOUT) begin
      v = {q.avg_ua, q.cur_ua};
    end else if (a == `LMSG_A_STATUS) begin
      v = {16'h0, q.subcnt, 1'(q.line), q.eff_peak, 1'b0, q.state};
    end else if (a[11:8] == `LMSG_A_DOTG_PAGE && int'(a[7:2]) < DOTS && a[1:0] == 2'h0) begin
      v = {24'h0, q.dot_gain[a[7:2]]};
    end else if (a[11:8] == `LMSG_A_DUTY_PAGE && int'(a[7:2]) < DOTS && a[1:0] == 2'h0) begin
      v = {16'h0, q.duty_sh[a[7:2]]};
    end else begin
      reg_read = 1'b0;
    end
  endfunction

  // 8-bit duty stretched to full scale
  function automatic logic [15:0] duty_of(input logic [15:0] raw, input logic wide);
    duty_of = wide ? raw : {raw[7:0], raw[7:0]};
  endfunction

  always_comb begin
    logic        hit;
    logic [31:0] val;
    logic [31:0] wv;
    logic [5:0]  widx;
    logic [10:0] pwm_c;
    logic [10:0] blk_c;
    logic [10:0] stg_c;
    logic [10:0] dly_c;
    logic [10:0] slot_end;
    logic [10:0] ta;
    logic [10:0] off;
    logic [15:0] step;
    logic [15:0] rmp;
    logic [15:0] dty;
    logic [5:0]  dot;
    logic        win;
    logic        run_rise;
    logic        vs_edge;
    logic        wide;
    hit      = 1'b0;
    val      = 32'h0;
    wv       = 32'h0;
    widx     = 6'h0;
    off      = 11'h0;
    rmp      = 16'h0;
    dty      = 16'h0;
    dot      = 6'h0;
    win      = 1'b0;
    pwm_c    = 11'h0;
    blk_c    = 11'h0;
    stg_c    = 11'h0;
    dly_c    = 11'h0;
    slot_end = 11'h0;
    ta       = 11'h0;
    step     = 16'h0;
    run_rise = 1'b0;
    vs_edge  = 1'b0;
    wide     = 1'b0;
    d        = q;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_hold = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_hold = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb  = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_hold && q.w_hold && !q.bvalid) begin
      d.aw_hold = 1'b0;
      d.w_hold  = 1'b0;
      d.bvalid  = 1'b1;
      hit       = reg_read(q.awaddr, val);
      d.bresp   = hit ? `LMSG_RESP_OKAY : `LMSG_RESP_SLVERR;
      wv        = merge(val, q.wdata, q.wstrb);
      widx      = q.awaddr[7:2];
      if (!hit) begin
        d.bresp = `LMSG_RESP_SLVERR;
      end else if (q.awaddr == `LMSG_A_CTRL) begin
        d.run       = wv[0];
        // Reserved mode code keeps the old mode
        if (wv[2:1] != 2'h3) begin
          d.mode = lmsg_pkg::lmsg_mode_e'(wv[2:1]);
        end
        d.two_lines = wv[3];
      end else if (q.awaddr == `LMSG_A_TIMING) begin
        d.rate_slow   = wv[0];
        d.blank_short = wv[1];
        d.stagger     = wv[2];
        d.delay_en    = wv[3];
      end else if (q.awaddr == `LMSG_A_COMP) begin
        d.comp = wv[5:0];
      end else if (q.awaddr == `LMSG_A_DEGHOST) begin
        d.dis_sel = wv[1:0];
        d.pre_sel = wv[3:2];
      end else if (q.awaddr == `LMSG_A_PEAK) begin
        d.peak = wv[2:0];
      end else if (q.awaddr == `LMSG_A_COLOR) begin
        d.color[0] = wv[6:0];
        d.color[1] = wv[14:8];
        d.color[2] = wv[22:16];
      end else if (q.awaddr == `LMSG_A_GSEL) begin
        if (int'(wv[5:0]) < DOTS) begin
          d.sel_dot = wv[5:0];
        end
      end else if (q.awaddr[11:8] == `LMSG_A_DOTG_PAGE) begin
        d.dot_gain[widx] = wv[7:0];
      end else if (q.awaddr[11:8] == `LMSG_A_DUTY_PAGE) begin
        // instant mode shows duty at once
        d.duty_sh[widx] = (q.mode == lmsg_pkg::LMSG_FRAME16) ? wv[15:0] : {8'h0, wv[7:0]};
        if (q.mode == lmsg_pkg::LMSG_INSTANT) begin
          d.duty_act[widx] = d.duty_sh[widx];
        end
      end
    end

    // Read channel: answer one cycle after the address is taken
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      hit      = reg_read(s_axi_araddr, val);
      d.rvalid = 1'b1;
      d.rdata  = hit ? val : 32'h0;
      d.rresp  = hit ? `LMSG_RESP_OKAY : `LMSG_RESP_SLVERR;
    end

    // frame modes apply latched codes on run rising
    run_rise   = q.run && !q.run_prev;
    d.run_prev = q.run;
    // deghost fields latch like the peak code
    if (q.mode == lmsg_pkg::LMSG_INSTANT || run_rise) begin
      d.eff_peak = q.peak;
      d.eff_dis  = q.dis_sel;
      d.eff_pre  = q.pre_sel;
    end

    // Sync pin: two flops before the edge detector
    d.vs1   = vsync;
    d.vs2   = q.vs1;
    d.vs3   = q.vs2;
    vs_edge = q.vs2 && !q.vs3;
    // frame modes hold duty until the sync pulse
    if (q.mode != lmsg_pkg::LMSG_INSTANT && vs_edge) begin
      d.duty_act = q.duty_sh;
    end

    // all durations are cycle counts of aclk
    pwm_c = q.rate_slow ? 11'(`LMSG_PWM_SLOW_CYC) : 11'(`LMSG_PWM_FAST_CYC);
    blk_c = q.blank_short ? 11'(`LMSG_BLK_SHORT_CYC) : 11'(`LMSG_BLK_LONG_CYC);
    stg_c = q.stagger ? 11'(`LMSG_STG_CYC) : 11'h0;
    dly_c = !q.delay_en ? 11'h0 : (q.rate_slow ? 11'(`LMSG_DLY_SLOW_CYC) : 11'(`LMSG_DLY_FAST_CYC));
    step  = q.rate_slow ? 16'(`LMSG_STEP_SLOW) : 16'(`LMSG_STEP_FAST);
    // slot is blank, active and two staggers
    slot_end = 11'(blk_c + pwm_c + (stg_c << 1) - 11'h1);
    ta       = 11'(q.tcnt - blk_c);
    wide     = (q.mode == lmsg_pkg::LMSG_FRAME16);

    case (q.state)
      lmsg_pkg::LMSG_IDLE: begin
        d.tcnt = 11'h0;
        d.line = '0;
        if (q.run) begin
          d.state = lmsg_pkg::LMSG_BLANK;
        end
      end
      lmsg_pkg::LMSG_BLANK: begin
        d.tcnt = 11'(q.tcnt + 11'h1);
        if (q.tcnt == 11'(blk_c - 11'h1)) begin
          d.state = lmsg_pkg::LMSG_ACTIVE;
        end
      end
      lmsg_pkg::LMSG_ACTIVE: begin
        d.tcnt = 11'(q.tcnt + 11'h1);
        if (q.tcnt == slot_end) begin
          d.tcnt  = 11'h0;
          d.state = lmsg_pkg::LMSG_BLANK;
          // sub-period ends after the last active line
          if (!q.two_lines || int'(q.line) == LINES - 1) begin
            d.line   = '0;
            d.subcnt = 8'(q.subcnt + 8'h1);
          end else begin
            d.line = LW'(q.line + 1'b1);
          end
        end
      end
      default: begin
        d.state = lmsg_pkg::LMSG_IDLE;
      end
    endcase
    if (!q.run) begin
      d.state = lmsg_pkg::LMSG_IDLE;
    end

    // Lines are driven only in the active part of a slot
    d.line_on = '0;
    if (q.state == lmsg_pkg::LMSG_ACTIVE) begin
      d.line_on[q.line] = 1'b1;
    end
    // lines that are off are discharged
    d.line_dis = ~d.line_on;

    for (int i = 0; i < SINKS; i++) begin
      case (grp(i))
        2'h0:    off = 11'h0;
        2'h1:    off = stg_c;
        default: off = 11'(stg_c << 1);
      endcase
      win = (q.state == lmsg_pkg::LMSG_ACTIVE) && (ta >= off) && (ta < 11'(off + pwm_c)) && (ta >= dly_c);
      rmp = 16'(32'(ta - off) * 32'(step));
      // spread spectrum dithers the low byte per sub-period
      if (wide) begin
        rmp[7:0] = rev8(q.subcnt);
      end
      dot          = 6'(int'(q.line) * SINKS + i);
      dty          = duty_of(q.duty_act[dot], wide);
      d.sink_on[i] = win && (dty > rmp);
    end

    // sinks that are off are pre-charged
    d.sink_pre = ~d.sink_on;

    // Gain readout of the selected dot, one cycle behind
    d.cur_ua = g_cur;
    d.avg_ua = g_avg;

    // Ready lines low while a transfer of the same kind is pending
    d.awready = !d.aw_hold && !d.bvalid;
    d.wready  = !d.w_hold && !d.bvalid;
    d.arready = !d.rvalid;

    if (!aresetn) begin
      d          = '0;
      d.state    = lmsg_pkg::LMSG_IDLE;
      d.mode     = lmsg_pkg::LMSG_INSTANT;
      d.two_lines = 1'b1;
      d.peak     = `LMSG_PEAK_RST;
      d.eff_peak = `LMSG_PEAK_RST;
      d.color    = {3{`LMSG_COLOR_RST}};
      d.dot_gain = {DOTS{`LMSG_DOTG_RST}};
      d.line_dis = '1;
      d.sink_pre = '1;
    end
  end

  always_ff @(posedge aclk) begin
    q <= d;
  end

  lmsg_gain_calc u_gain (
    .peak_code  (q.eff_peak),
    .color_code (q.color[grp(int'(q.sel_dot) % SINKS)]),
    .dot_code   (q.dot_gain[q.sel_dot]),
    .two_lines  (q.two_lines),
    .sink_ua    (g_cur),
    .avg_ua     (g_avg)
  );

  assign s_axi_awready         = q.awready;
  assign s_axi_wready          = q.wready;
  assign s_axi_bresp           = q.bresp;
  assign s_axi_bvalid          = q.bvalid;
  assign s_axi_arready         = q.arready;
  assign s_axi_rdata           = q.rdata;
  assign s_axi_rresp           = q.rresp;
  assign s_axi_rvalid          = q.rvalid;
  assign line_on               = q.line_on;
  assign line_discharge        = q.line_dis;
  assign line_discharge_level  = q.eff_dis;
  assign sink_on               = q.sink_on;
  assign sink_precharge        = q.sink_pre;
  assign sink_precharge_level  = q.eff_pre;
  assign low_level_comp_first  = q.comp[1:0];
  assign low_level_comp_second = q.comp[3:2];
  assign low_level_comp_third  = q.comp[5:4];
endmodule

// ---- tb/lmsg_chk.sv ----
// Purpose: port checks of the scan and gain block
// Assumes: bound into lmsg_top
// Notes:   slot limits are the widest legal settings
`timescale 1ns/1ps
module lmsg_chk #(
  parameter int LINES = 2,
  parameter int SINKS = 18
) (
  // Clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // Bus answers
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  // Matrix pins
  input wire logic [LINES-1:0] line_on,
  input wire logic [LINES-1:0] line_discharge,
  input wire logic [SINKS-1:0] sink_on,
  input wire logic [SINKS-1:0] sink_precharge
);
  logic [9:0] on_q, off_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Off count saturates so long idle stays legal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_q  <= 10'h0;
      off_q <= 10'h0;
    end else begin
      on_q  <= |line_on ? on_q + 10'h1 : 10'h0;
      off_q <= |line_on ? 10'h0 : off_q + {9'h0, off_q != 10'h3ff};
    end
  end
  disch_mirror_a: assert property (line_discharge == ~line_on) else $error("discharge wrong");
  prech_mirror_a: assert property (sink_precharge == ~sink_on) else $error("precharge wrong");
  line_single_a: assert property ($onehot0(line_on)) else $error("two lines on");
  sink_in_line_a: assert property (|sink_on |-> |line_on) else $error("sink outside line");
  slot_max_a: assert property (on_q <= 10'd814) else $error("line slot too long");
  blank_min_a: assert property ($rose(|line_on) |-> off_q >= 10'd25) else $error("blank too short");
  bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid held");
  rresp_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid held");
  cover property ($fell(line_on[0]) ##[1:60] line_on[1]);
  cover property (sink_on[0] && on_q == 10'd799);
  cover property ($rose(|line_on) && off_q == 10'd25);
endmodule
bind lmsg_top lmsg_chk #(.LINES(LINES), .SINKS(SINKS)) u_chk (.*);

// ---- tb/lmsg_led_model.sv ----
// Purpose: matrix of 36 dots on two scan lines
// Assumes: lines and sinks active high
// Notes:   flags any sink current with no line switched
`timescale 1ns/1ps
module lmsg_led_model (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Matrix pins
  input wire logic [1:0]  line_on,
  input wire logic [17:0] sink_on,
  // Observation
  output logic            ghost
);
  // dot conducts only on its line
  always_ff @(posedge aclk) begin
    if (!aresetn) ghost <= 1'b0;
    else if (|sink_on && !(|line_on)) ghost <= 1'b1;
  end
endmodule

// ---- tb/tb_led_matrix_scan_and_gain.sv ----
// Purpose: self-checking bench of the scan and gain block
// Assumes: AXI4-Lite map of the defines header
// Notes:   prot tied; frame sync driven in the last scenario
`timescale 1ns/1ps
`include "lmsg_defines.svh"
module tb_led_matrix_scan_and_gain;
  logic        aclk = 1'b0, aresetn = 1'b0, vsync = 1'b0, ghost;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0, wd, sd, w = 12'h0, s = 12'h0;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, c;
  logic [3:0]  s_axi_wstrb = 4'hf, tm;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, line_on, line_discharge, m;
  logic [1:0]  line_discharge_level, sink_precharge_level;
  logic [1:0]  low_level_comp_first, low_level_comp_second, low_level_comp_third;
  logic [17:0] sink_on, sink_precharge;
  logic [33:0] q_rd[$];
  logic [1:0]  q_b[$];
  logic [25:0] q_ln[$];
  int          failures = 0, cmp_count = 0, n, k;
  int          pk[8] = '{3000, 5000, 10000, 15000, 20000, 30000, 40000, 50000};
  int          cfg[5] = '{0, 6, 9, 8, 0};
  lmsg_top DUT (.*);
  lmsg_led_model MDL (.aclk(aclk), .aresetn(aresetn), .line_on(line_on), .sink_on(sink_on), .ghost(ghost));
  initial forever #10 aclk = ~aclk;
  task automatic check(string what, logic [33:0] e, logic [33:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic conclude();
    $display("failures %0d cmp_count %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic lim(int i, int top);
    if (i >= top) begin
      failures++;
      conclude();
    end
  endtask
  // Waits until every expected line pulse has been seen
  task automatic drain();
    for (n = 0; n < 5000 && q_ln.size() != 0; n++) @(posedge aclk);
    lim(n, 5000);
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] r = 2'h0);
    int i;
    @(posedge aclk);
    q_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 100 && !s_axi_bvalid; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    lim(i, 100);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] d, logic [1:0] r = 2'h0);
    int i;
    @(posedge aclk);
    q_rd.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 100 && !s_axi_rvalid; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    lim(i, 100);
  endtask
  // Results are judged at the edge that carries them
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) check("rdata", q_rd.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) check("bresp", q_b.pop_front(), s_axi_bresp);
    if (|line_on) begin
      w = w + 12'h1;
      s = s + {11'h0, sink_on[0]};
      m = line_on;
    end else if (w != 12'h0) begin
      if (q_ln.size() != 0) check("line pulse", q_ln.pop_front(), {m, w, s});
      w = 12'h0;
      s = 12'h0;
    end
  end
  initial begin
    void'($urandom(32'h0acc));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`LMSG_A_PEAK, 32'h3);
    rd(`LMSG_A_COLOR, 32'h00404040);
    rd(12'h104, 32'h80);
    wr(`LMSG_A_GSEL, 32'h0);
    rd(`LMSG_A_GOUT, {16'd1897, 16'd3794});
    c = $urandom & 32'h007f7f7f;
    wr(`LMSG_A_COLOR, c);
    rd(`LMSG_A_COLOR, c);
    k = $urandom_range(35);
    c = $urandom & 32'hff;
    wr(12'h100 + 12'(4 * k), c);
    rd(12'h100 + 12'(4 * k), c);
    wr(12'h100, 32'hff);
    wr(`LMSG_A_COLOR, 32'h007f7f7f);
    for (k = 0; k < 8; k++) begin
      wr(`LMSG_A_PEAK, 32'(k));
      rd(`LMSG_A_GOUT, {16'(pk[k] / 2), 16'(pk[k])});
    end
    wr(`LMSG_A_CTRL, 32'h0);
    rd(`LMSG_A_GOUT, {16'd50000, 16'd50000});
    wr(`LMSG_A_CTRL, 32'h2);
    wr(`LMSG_A_PEAK, 32'h2);
    wr(`LMSG_A_DEGHOST, 32'h6);
    rd(`LMSG_A_GOUT, {16'd50000, 16'd50000});
    check("levels", 4'h0, {sink_precharge_level, line_discharge_level});
    wr(`LMSG_A_CTRL, 32'h3);
    rd(`LMSG_A_GOUT, {16'd10000, 16'd10000});
    check("levels", 4'h6, {sink_precharge_level, line_discharge_level});
    wr(`LMSG_A_CTRL, 32'h0);
    wr(12'h104, 32'hff);
    wr(`LMSG_A_GSEL, 32'h1);
    wr(`LMSG_A_COLOR, 32'h007f007f);
    rd(`LMSG_A_GOUT, 32'h0);
    wr(`LMSG_A_COMP, 32'h39);
    check("comp", 6'h39, {low_level_comp_third, low_level_comp_second, low_level_comp_first});
    wr(12'h0fc, 32'h1, 2'h2);
    rd(12'h0fc, 32'h0, 2'h2);
    wr(12'h200, 32'hff);
    for (k = 0; k < 5; k++) begin
      tm = cfg[k][3:0];
      wr(`LMSG_A_CTRL, 32'h0);
      wr(`LMSG_A_TIMING, 32'(tm));
      wd = (tm[0] ? 12'd800 : 12'd400) + (tm[2] ? 12'd14 : 12'd0);
      sd = (tm[0] ? 12'd800 : 12'd400) - (tm[3] ? (tm[0] ? 12'd4 : 12'd2) : 12'd0);
      q_ln.push_back({2'h1, wd, sd});
      q_ln.push_back(k < 4 ? {2'h2, wd, 12'h0} : {2'h1, wd, sd});
      wr(`LMSG_A_CTRL, k < 4 ? 32'h9 : 32'h1);
      drain();
    end
    // Frame mode holds duty until sync; 16-bit depth gives 202 on-cycles
    wr(`LMSG_A_CTRL, 32'h4);
    wr(12'h200, 32'h8000);
    vsync <= 1'b1;
    repeat (4) @(posedge aclk);
    vsync <= 1'b0;
    wr(12'h200, 32'h0);
    q_ln.push_back({2'h1, 12'd400, 12'd202});
    wr(`LMSG_A_CTRL, 32'h5);
    drain();
    q_ln.push_back({2'h1, 12'd400, 12'h0});
    vsync <= 1'b1;
    drain();
    check("ghost", 1'b0, ghost);
    conclude();
  end
endmodule
